// >>> rtl/pmt_edge_det.sv
// rise and fall detection on the synchronous control inputs
`timescale 1ns/1ps
`include "pmt_regs.svh"

module pmt_edge_det
   import pmt_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     arst_n,
   input  wire logic [`PMT_NUM_IN-1:0]   level,
   output logic      [`PMT_NUM_IN-1:0]   rise,
   output logic      [`PMT_NUM_IN-1:0]   fall
);

   typedef struct packed {
      logic [`PMT_NUM_IN-1:0] prev;
   } pmt_edge_s;

   pmt_edge_s q;
   pmt_edge_s d;

   // remember last level; all inputs read low at start-up
   always_comb begin
      d      = q;
      d.prev = level;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rise = level & ~q.prev;
   assign fall = ~level & q.prev;

endmodule : pmt_edge_det

// >>> rtl/pmt_pkg.sv
// types shared by the multimode timer modules
package pmt_pkg;

   // ************************************************************
   // operating modes and sequencer states
   // ************************************************************
   typedef enum logic [1:0] {
      PMT_MODE_ONE_SHOT = 2'h0,
      PMT_MODE_ON_DELAY = 2'h1,
      PMT_MODE_OFF_DLY  = 2'h2,
      PMT_MODE_PULSE    = 2'h3
   } pmt_mode_e;

   // gray codes along idle -> timing -> done, armed sits beside
   typedef enum logic [1:0] {
      PMT_ST_IDLE   = 2'h0,
      PMT_ST_TIMING = 2'h1,
      PMT_ST_DONE   = 2'h3,
      PMT_ST_ARMED  = 2'h2
   } pmt_state_e;

   // input vector bit positions for the edge detector
   typedef enum logic [2:0] {
      PMT_IN_GATE  = 3'h0,
      PMT_IN_CLEAR = 3'h1,
      PMT_IN_ONE   = 3'h2,
      PMT_IN_OND   = 3'h3,
      PMT_IN_OFF   = 3'h4,
      PMT_IN_PLS   = 3'h5
   } pmt_in_e;

   typedef struct packed {
      pmt_state_e  state;
      pmt_mode_e   mode;
      logic        status;
      logic        gate;
      logic [31:0] elapsed;
      logic [31:0] tconst;
      logic [31:0] tc_reg;
      logic [31:0] rdata;
   } pmt_core_s;

endpackage : pmt_pkg

// >>> rtl/pmt_regs.svh
// offsets, field positions, reset values and timing counts of the multimode timer
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH

// ************************************************************
// register offsets (byte addresses on the plain port)
// ************************************************************
`define PMT_ADDR_W        4
`define PMT_OFS_TCONST    4'h0
`define PMT_OFS_STATUS    4'h4
`define PMT_OFS_ELAPSED   4'h8

// ************************************************************
// status register fields
// ************************************************************
`define PMT_STAT_OUT_BIT  0
`define PMT_STAT_GATE_BIT 1
`define PMT_STAT_ST_LO    4
`define PMT_STAT_ST_HI    5
`define PMT_STAT_MD_LO    8
`define PMT_STAT_MD_HI    9

// ************************************************************
// reset values
// ************************************************************
`define PMT_RST_TCONST    32'h0000_0000
`define PMT_RST_ELAPSED   32'h0000_0000
`define PMT_RST_STATUS    1'b0

// ************************************************************
// timing: one millisecond time base at a 100 ns clock
// ************************************************************
`define PMT_CLK_PERIOD_NS 100
`define PMT_TICK_NS       1000000
`define PMT_TICK_CYCLES   (`PMT_TICK_NS / `PMT_CLK_PERIOD_NS)
`define PMT_NUM_IN        6

`endif

// >>> rtl/pmt_tick_gen.sv
// free running millisecond time base
`timescale 1ns/1ps
`include "pmt_regs.svh"

module pmt_tick_gen
   import pmt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `PMT_TICK_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic arst_n,
   output logic      tick
);

   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } pmt_tick_s;

   pmt_tick_s q;
   pmt_tick_s d;

   // count down one period, pulse for one cycle on wrap
   always_comb begin
      d      = q;
      d.tick = 1'b0;
      if (q.cnt == 32'h0) begin
         d.cnt  = 32'(TICK_CYCLES - 1);
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt - 32'h1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule : pmt_tick_gen

// >>> rtl/pmt_timer.sv
// multimode millisecond timer with status bit, elapsed count and register port
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "pmt_regs.svh"

// Function
// - start-up clears status output and elapsed count to zero
// - gate low after triggering freezes timing; gate high resumes it
// - every trigger forces the internal gate active high
// - every trigger forces the clear input inactive, logic 0
// - clear rising edge drops status, zeroes elapsed, waits for a fresh trigger
// - four triggers: one-shot, on-delay, off-delay, pulse limiting
// - time constant in milliseconds, full unsigned 32-bit range
// - status bit and elapsed count both readable
// - one-shot trigger rise sets status and starts count from zero
// - one-shot expiry stops timing, drops status, holds elapsed value
// - one-shot ignores its trigger edges while timing
// - after one-shot completes only a fresh rise restarts it
// - on-delay trigger rise starts count from zero, status stays low
// - on-delay expiry stops timing, status high until trigger falls
// - on-delay holds elapsed until the next trigger rise
// - on-delay trigger fall before expiry halts, keeps count, status low
// - off-delay rise sets status, fall starts timing, expiry drops status
// - pulse-limit trigger fall before expiry stops timing, status low
module pmt_timer
   import pmt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `PMT_TICK_CYCLES
) (
   input  wire logic                    core_clk,
   input  wire logic                    arst_n,
   input  wire logic                    run_gate,
   input  wire logic                    clear_input,
   input  wire logic                    one_shot_trigger,
   input  wire logic                    on_delay_trigger,
   input  wire logic                    off_delay_trigger,
   input  wire logic                    pulse_limit_trigger,
   input  wire logic [`PMT_ADDR_W-1:0]  reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   output logic                         timer_status,
   output logic      [31:0]             elapsed_ms
);

   // ************************************************************
   // time base and edge detection
   // ************************************************************
   logic                   tick;
   logic [`PMT_NUM_IN-1:0] level;
   logic [`PMT_NUM_IN-1:0] rise;
   logic [`PMT_NUM_IN-1:0] fall;

   assign level = {pulse_limit_trigger, off_delay_trigger, on_delay_trigger,
                   one_shot_trigger, clear_input, run_gate};

   // one shared time base keeps every count in step
   pmt_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .tick     (tick)
   );

   pmt_edge_det u_edge (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .level    (level),
      .rise     (rise),
      .fall     (fall)
   );

   // ************************************************************
   // state
   // ************************************************************
   pmt_core_s q;
   pmt_core_s d;
   logic      trig_take;
   pmt_mode_e trig_mode;
   logic      clr_hit;
   logic      expired;

   // true when the elapsed count has met the latched constant
   function automatic logic at_limit(input logic [31:0] el, input logic [31:0] tc);
      at_limit = (el == tc);
   endfunction : at_limit

   // status word as seen by software
   function automatic logic [31:0] pack_status(input pmt_core_s s);
      logic [31:0] w;
      w = 32'h0;
      w[`PMT_STAT_OUT_BIT]                 = s.status;
      w[`PMT_STAT_GATE_BIT]                = s.gate;
      w[`PMT_STAT_ST_HI:`PMT_STAT_ST_LO]   = s.state;
      w[`PMT_STAT_MD_HI:`PMT_STAT_MD_LO]   = s.mode;
      pack_status = w;
   endfunction : pack_status

   // trigger arbitration: lowest numbered trigger wins a tie
   always_comb begin
      trig_take = 1'b0;
      trig_mode = PMT_MODE_ONE_SHOT;
      if (rise[PMT_IN_ONE] && !(q.state == PMT_ST_TIMING && q.mode == PMT_MODE_ONE_SHOT)) begin
         trig_take = 1'b1;
         trig_mode = PMT_MODE_ONE_SHOT;
      end else if (rise[PMT_IN_OND]) begin
         trig_take = 1'b1;
         trig_mode = PMT_MODE_ON_DELAY;
      end else if (rise[PMT_IN_OFF]) begin
         trig_take = 1'b1;
         trig_mode = PMT_MODE_OFF_DLY;
      end else if (rise[PMT_IN_PLS]) begin
         trig_take = 1'b1;
         trig_mode = PMT_MODE_PULSE;
      end
      // a trigger forces clear inactive, so a same-cycle clear edge is dropped
      clr_hit = rise[PMT_IN_CLEAR] && !trig_take;
      expired = at_limit(q.elapsed, q.tconst);
   end

   // ************************************************************
   // sequencer, counter and register port
   // ************************************************************
   always_comb begin
      d       = q;
      d.rdata = 32'h0;

      // software side: constant register and read-back
      if (reg_wr && reg_addr == `PMT_OFS_TCONST) begin
         d.tc_reg = reg_wdata;
      end
      if (reg_rd) begin
         if (reg_addr == `PMT_OFS_TCONST) begin
            d.rdata = q.tc_reg;
         end else if (reg_addr == `PMT_OFS_STATUS) begin
            d.rdata = pack_status(q);
         end else if (reg_addr == `PMT_OFS_ELAPSED) begin
            d.rdata = q.elapsed;
         end else begin
            d.rdata = 32'h0;
         end
      end

      // gate follows pin edges between triggers
      if (rise[PMT_IN_GATE]) begin
         d.gate = 1'b1;
      end else if (fall[PMT_IN_GATE]) begin
         d.gate = 1'b0;
      end

      if (clr_hit) begin
         d.status  = 1'b0;
         d.elapsed = 32'h0;
         d.state   = PMT_ST_IDLE;
      end else if (trig_take) begin
         d.mode    = trig_mode;
         d.gate    = 1'b1;
         d.tconst  = q.tc_reg;
         d.elapsed = 32'h0;
         case (trig_mode)
            PMT_MODE_ONE_SHOT: begin
               d.status = 1'b1;
               d.state  = PMT_ST_TIMING;
            end
            PMT_MODE_ON_DELAY: begin
               d.status = 1'b0;
               d.state  = PMT_ST_TIMING;
            end
            PMT_MODE_OFF_DLY: begin
               d.status = 1'b1;
               d.state  = PMT_ST_ARMED;
            end
            default: begin
               d.status = 1'b1;
               d.state  = PMT_ST_TIMING;
            end
         endcase
      end else begin
         case (q.state)
            PMT_ST_TIMING: begin
               if (q.mode == PMT_MODE_ON_DELAY && fall[PMT_IN_OND] && !expired) begin
                  d.status = 1'b0;
                  d.state  = PMT_ST_DONE;
               end else if (q.mode == PMT_MODE_PULSE && fall[PMT_IN_PLS] && !expired) begin
                  d.status = 1'b0;
                  d.state  = PMT_ST_DONE;
               end else if (expired) begin
                  // only on-delay ends high; every other mode ends low
                  d.status = (q.mode == PMT_MODE_ON_DELAY);
                  d.state  = PMT_ST_DONE;
               end else if (tick && q.gate) begin
                  d.elapsed = q.elapsed + 32'h1;
               end
            end
            PMT_ST_ARMED: begin
               if (fall[PMT_IN_OFF]) begin
                  d.elapsed = 32'h0;
                  d.state   = PMT_ST_TIMING;
               end
            end
            PMT_ST_DONE: begin
               // elapsed stays put here until the next trigger
               if (q.mode == PMT_MODE_ON_DELAY && fall[PMT_IN_OND]) begin
                  d.status = 1'b0;
               end
            end
            default: begin
               d.state = PMT_ST_IDLE;
            end
         endcase
      end
   end

   // all state cleared at start-up, gate and clear start inactive
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q         <= '0;
         q.status  <= `PMT_RST_STATUS;
         q.elapsed <= `PMT_RST_ELAPSED;
         q.tc_reg  <= `PMT_RST_TCONST;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata    = q.rdata;
   assign timer_status = q.status;
   assign elapsed_ms   = q.elapsed;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   logic quiet;
   assign quiet = !clr_hit && !trig_take;

   sequence s_mono_run;
      q.state == PMT_ST_TIMING && q.mode == PMT_MODE_ONE_SHOT;
   endsequence

   sequence s_on_run;
      q.state == PMT_ST_TIMING && q.mode == PMT_MODE_ON_DELAY;
   endsequence

   chk_clear_zeroes: assert property (clr_hit |=> !timer_status && elapsed_ms == 32'h0 && q.state == PMT_ST_IDLE)
      else $error("clear edge did not reset the timer");

   chk_mono_start: assert property (trig_take && trig_mode == PMT_MODE_ONE_SHOT
      |=> timer_status && elapsed_ms == 32'h0 && q.state == PMT_ST_TIMING)
      else $error("one-shot trigger did not start the timer");

   chk_on_start: assert property (trig_take && trig_mode == PMT_MODE_ON_DELAY
      |=> !timer_status && elapsed_ms == 32'h0)
      else $error("on-delay trigger did not start with status low");

   chk_trig_gate: assert property (trig_take |=> q.gate && q.tconst == $past(q.tc_reg))
      else $error("trigger did not force gate or load constant");

   chk_mono_expire: assert property (s_mono_run ##0 (expired && quiet)
      |=> !timer_status && q.state == PMT_ST_DONE ##1 $stable(elapsed_ms))
      else $error("one-shot expiry wrong");

   chk_mono_ignore: assert property (s_mono_run ##0 (quiet && !expired && (rise[PMT_IN_ONE] || fall[PMT_IN_ONE]))
      |=> q.state == PMT_ST_TIMING && timer_status)
      else $error("one-shot reacted to its trigger while timing");

   chk_gate_freeze: assert property (q.state == PMT_ST_TIMING && !q.gate && quiet && !rise[PMT_IN_GATE]
      |=> $stable(elapsed_ms))
      else $error("elapsed count moved with gate low");

   chk_count_tick: assert property (q.state == PMT_ST_TIMING && q.gate && tick && !expired && quiet
      && !((q.mode == PMT_MODE_ON_DELAY && fall[PMT_IN_OND]) || (q.mode == PMT_MODE_PULSE && fall[PMT_IN_PLS]))
      |=> elapsed_ms == $past(elapsed_ms) + 32'h1)
      else $error("elapsed count did not advance on tick");

   chk_on_expire: assert property (s_on_run ##0 (expired && quiet)
      |=> timer_status && q.state == PMT_ST_DONE)
      else $error("on-delay expiry did not raise status");

   chk_on_abort: assert property (s_on_run ##0 (!expired && quiet && fall[PMT_IN_OND])
      |=> !timer_status && $stable(elapsed_ms) && q.state == PMT_ST_DONE)
      else $error("on-delay early fall handled wrongly");

   chk_on_release: assert property (q.state == PMT_ST_DONE && q.mode == PMT_MODE_ON_DELAY && quiet && fall[PMT_IN_OND]
      |=> !timer_status && $stable(elapsed_ms))
      else $error("on-delay release did not drop status");

   chk_off_start: assert property (q.state == PMT_ST_ARMED && quiet && fall[PMT_IN_OFF]
      |=> q.state == PMT_ST_TIMING && elapsed_ms == 32'h0 && timer_status)
      else $error("off-delay fall did not start timing");

   chk_pulse_cut: assert property (q.state == PMT_ST_TIMING && q.mode == PMT_MODE_PULSE && !expired && quiet
      && fall[PMT_IN_PLS] |=> !timer_status && $stable(elapsed_ms))
      else $error("pulse-limit early fall handled wrongly");

   chk_read_elapsed: assert property (reg_rd && reg_addr == `PMT_OFS_ELAPSED
      |=> reg_rdata == $past(elapsed_ms))
      else $error("elapsed read-back mismatch");

endmodule : pmt_timer

// >>> testbench/pmt_ctrl_model.sv
// controller program model driving the timer's gate, clear and trigger pins
`timescale 1ns/1ps

module pmt_ctrl_model
   import pmt_pkg::*;
(
   input  wire logic core_clk,
   output logic      run_gate,
   output logic      clear_input,
   output logic      one_shot_trigger,
   output logic      on_delay_trigger,
   output logic      off_delay_trigger,
   output logic      pulse_limit_trigger
);

   // ************************************************************
   // pin image, bit order as in the design's input vector
   // ************************************************************
   logic [5:0] pin_q = 6'h01;  // gate starts high, the rest low

   // one wire per pin, like the program's output stage
   assign run_gate            = pin_q[PMT_IN_GATE];
   assign clear_input         = pin_q[PMT_IN_CLEAR];
   assign one_shot_trigger    = pin_q[PMT_IN_ONE];
   assign on_delay_trigger    = pin_q[PMT_IN_OND];
   assign off_delay_trigger   = pin_q[PMT_IN_OFF];
   assign pulse_limit_trigger = pin_q[PMT_IN_PLS];

   // a scan changes pins only just after an edge, never between edges
   task automatic set_pin(input pmt_in_e idx, input logic val);
      @(posedge core_clk);
      pin_q[idx] <= val;
   endtask : set_pin

   // several pins in one scan, so that edges land on the same sample
   task automatic set_all(input logic [5:0] val);
      @(posedge core_clk);
      pin_q <= val;
   endtask : set_all
endmodule : pmt_ctrl_model

// >>> testbench/tb_plc_multimode_timer.sv
// self-checking bench for the multimode millisecond timer
`timescale 1ns/1ps
`include "pmt_regs.svh"

module tb_plc_multimode_timer;
   import pmt_pkg::*;

   // ************************************************************
   // short tick keeps the run small; timing expectations scale with it, except the fixed 78 to 86 cycle pacing window
   // ************************************************************
   localparam int unsigned TICKS   = 4;
   localparam logic [31:0] K_SHORT = 32'h0000_0003;
   localparam logic [31:0] K_LONG  = 32'h0000_0014;

   logic                   core_clk  = 1'b0;
   logic                   arst_n    = 1'b0;
   logic [`PMT_ADDR_W-1:0] reg_addr  = '0;
   logic [31:0]            reg_wdata = '0;
   logic                   reg_wr    = 1'b0;
   logic                   reg_rd    = 1'b0;
   logic [31:0]            reg_rdata, elapsed_ms, rd_val, snap;
   logic                   timer_status, run_gate, clear_input;
   logic                   os_trg, od_trg, of_trg, pl_trg;
   int                     err_total = 0;
   int                     n_tests   = 0;
   int                     n, t0, cyc_cnt = 0;

   pmt_timer #(.TICK_CYCLES(TICKS)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .run_gate(run_gate),
      .clear_input(clear_input), .one_shot_trigger(os_trg), .on_delay_trigger(od_trg),
      .off_delay_trigger(of_trg), .pulse_limit_trigger(pl_trg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_status(timer_status),
      .elapsed_ms(elapsed_ms));

   pmt_ctrl_model u_ctl (.core_clk(core_clk), .run_gate(run_gate), .clear_input(clear_input),
      .one_shot_trigger(os_trg), .on_delay_trigger(od_trg), .off_delay_trigger(of_trg),
      .pulse_limit_trigger(pl_trg));

   // 100 ns clock and a free cycle count for span measurements
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc_cnt <= cyc_cnt + 1;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] b2w(input logic b);
      return {31'h0, b};
   endfunction : b2w

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // pin set after one edge, sampled at the next; outputs read in the cycle they first stand
   task automatic fire(input pmt_in_e idx, input logic val);
      u_ctl.set_pin(idx, val);
      repeat (2) @(negedge core_clk);
   endtask : fire

   task automatic idle(input int k);
      repeat (k) @(negedge core_clk);
   endtask : idle

   task automatic reg_write(input logic [`PMT_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   // read data stands only in the cycle after the strobe
   task automatic reg_read(input logic [`PMT_ADDR_W-1:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(negedge core_clk);
      rd_val = reg_rdata;
   endtask : reg_read

   // bounded wait on the status bit; a stuck status counts as a mismatch
   task automatic wait_st(input logic v);
      n = 0;
      while (timer_status !== v && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      check("status wait", b2w(timer_status), b2w(v));
   endtask : wait_st

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      close_out();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      idle(1);
      check("status at start", b2w(timer_status), 32'h0);
      check("elapsed at start", elapsed_ms, 32'h0);
      reg_read(`PMT_OFS_TCONST);
      check("tconst reset", rd_val, `PMT_RST_TCONST);
      idle(1);
      check("rdata back to zero", reg_rdata, 32'h0);
      reg_read(4'hc);
      check("unmapped read", rd_val, 32'h0);
      reg_write(`PMT_OFS_TCONST, 32'hffff_ffff);
      reg_read(`PMT_OFS_TCONST);
      check("tconst max", rd_val, 32'hffff_ffff);
      reg_write(`PMT_OFS_ELAPSED, 32'h1234_5678);
      reg_read(`PMT_OFS_ELAPSED);
      check("elapsed read only", rd_val, 32'h0);
      // each trigger selects its own mode; a later rise overrides the earlier one
      for (int i = 0; i < 4; i++) begin
         fire(pmt_in_e'(3'(PMT_IN_ONE + i)), 1'b1);
         reg_read(`PMT_OFS_STATUS);
         check("mode field", {30'h0, rd_val[`PMT_STAT_MD_HI:`PMT_STAT_MD_LO]}, {30'h0, 2'(i)});
         fire(pmt_in_e'(3'(PMT_IN_ONE + i)), 1'b0);
      end
      fire(PMT_IN_CLEAR, 1'b1);
      check("status after clear", b2w(timer_status), 32'h0);
      check("elapsed after clear", elapsed_ms, 32'h0);
      reg_read(`PMT_OFS_STATUS);
      check("idle after clear", {30'h0, rd_val[`PMT_STAT_ST_HI:`PMT_STAT_ST_LO]}, 32'h0);
      fire(PMT_IN_CLEAR, 1'b0);
      // one-shot with the gate dropped beforehand: the trigger must turn it back on
      reg_write(`PMT_OFS_TCONST, K_LONG);
      fire(PMT_IN_GATE, 1'b0);
      t0 = cyc_cnt;
      fire(PMT_IN_ONE, 1'b1);
      check("oneshot status", b2w(timer_status), 32'h1);
      check("oneshot start", elapsed_ms, 32'h0);
      reg_read(`PMT_OFS_STATUS);
      check("gate forced on", b2w(rd_val[`PMT_STAT_GATE_BIT]), 32'h1);
      fire(PMT_IN_ONE, 1'b0);
      fire(PMT_IN_ONE, 1'b1);
      check("oneshot edges ignored", b2w(elapsed_ms != 32'h0), 32'h1);
      wait_st(1'b0);
      check("oneshot final", elapsed_ms, K_LONG);
      check("tick pacing", b2w((cyc_cnt - t0) >= 78 && (cyc_cnt - t0) <= 86), 32'h1);
      idle(20);
      check("no restart held", b2w(timer_status), 32'h0);
      check("final kept", elapsed_ms, K_LONG);
      fire(PMT_IN_ONE, 1'b0);
      fire(PMT_IN_ONE, 1'b1);
      check("fresh rise", b2w(timer_status), 32'h1);
      // gate freeze and resume in mid-count
      fire(PMT_IN_GATE, 1'b1);
      fire(PMT_IN_GATE, 1'b0);
      snap = elapsed_ms;
      idle(12);
      check("frozen", elapsed_ms, snap);
      fire(PMT_IN_GATE, 1'b1);
      idle(12);
      check("resumed", b2w(elapsed_ms > snap), 32'h1);
      fire(PMT_IN_CLEAR, 1'b1);
      idle(12);
      check("clear holds idle", elapsed_ms, 32'h0);
      check("clear drops status", b2w(timer_status), 32'h0);
      // clear and trigger rise together: the trigger wins
      u_ctl.set_all(6'h01);
      u_ctl.set_all(6'h07);
      idle(3);
      check("clear dropped", b2w(timer_status), 32'h1);
      u_ctl.set_all(6'h01);
      // on-delay, expiry then release
      reg_write(`PMT_OFS_TCONST, K_SHORT);
      fire(PMT_IN_OND, 1'b1);
      check("ondly status low", b2w(timer_status), 32'h0);
      check("ondly start", elapsed_ms, 32'h0);
      wait_st(1'b1);
      check("ondly at expiry", elapsed_ms, K_SHORT);
      idle(12);
      check("ondly stays high", b2w(timer_status), 32'h1);
      check("ondly count held", elapsed_ms, K_SHORT);
      fire(PMT_IN_OND, 1'b0);
      check("ondly release", b2w(timer_status), 32'h0);
      check("ondly count kept", elapsed_ms, K_SHORT);
      // on-delay released early
      reg_write(`PMT_OFS_TCONST, K_LONG);
      fire(PMT_IN_OND, 1'b1);
      idle(12);
      fire(PMT_IN_OND, 1'b0);
      snap = elapsed_ms;
      idle(12);
      check("ondly early status", b2w(timer_status), 32'h0);
      check("ondly partial", elapsed_ms, snap);
      check("ondly partial range", b2w(snap != 32'h0 && snap < K_LONG), 32'h1);
      // off-delay
      reg_write(`PMT_OFS_TCONST, K_SHORT);
      fire(PMT_IN_OFF, 1'b1);
      idle(20);
      check("offdly armed", b2w(timer_status), 32'h1);
      fire(PMT_IN_OFF, 1'b0);
      check("offdly from zero", elapsed_ms, 32'h0);
      wait_st(1'b0);
      check("offdly expiry", elapsed_ms, K_SHORT);
      // pulse limiting cut short by the trigger's fall
      reg_write(`PMT_OFS_TCONST, K_LONG);
      fire(PMT_IN_PLS, 1'b1);
      check("pulse on", b2w(timer_status), 32'h1);
      idle(12);
      fire(PMT_IN_PLS, 1'b0);
      snap = elapsed_ms;
      idle(12);
      check("pulse cut", b2w(timer_status), 32'h0);
      check("pulse kept", elapsed_ms, snap);
      check("pulse partial range", b2w(snap != 32'h0 && snap < K_LONG), 32'h1);
      close_out();
   end
endmodule : tb_plc_multimode_timer
